//--- shared/cfg_load_map.vh
// Constants of the power-state and configuration-load controller.
// Assumes an including file that uses these as plain `define macros.
`ifndef CFG_LOAD_MAP_VH
`define CFG_LOAD_MAP_VH

// Register word addresses
`define REG_CTRL 2'h0
`define REG_STATUS 2'h1
`define REG_COUNT 2'h2

// Control register fields and reset value
`define CTRL_KEEP_RAM 0
`define CTRL_PIN_KEEP 1
`define CTRL_RAM_EN_LO 2
`define CTRL_RAM_EN_HI 3
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 5
`define CTRL_RESET 8'h00

// Status register fields
`define STAT_STATE_HI 2
`define STAT_VALID 3
`define STAT_OVERRUN 4

// Boot source encodings
`define MODE_OTP 2'h0
`define MODE_FLASH 2'h1
`define MODE_MCU 2'h2

// Serial pins inside the pin vector
`define PIN_SCLK 3
`define PIN_SEL 4
`define PIN_SIN 5
`define PIN_SOUT 6

// Timing
`define CLK_PERIOD_NS 10
`define SCLK_HALF_NS 40
`define SCLK_HALF_CYC (`SCLK_HALF_NS / `CLK_PERIOD_NS)
`define FLASH_READ_CMD 8'h0B

`endif

//--- hdl/config_load_power_state_ctrl.v
// Power-state control and configuration loader of a small logic array.
// Assumes pins and power controls arrive asynchronous to clk; the one-time
// store read port is synchronous to clk with one cycle of read latency.
// Notes on behaviour
// RL1: Power-on reset holds reset, pins float.
// RL2: Reset/off drops config, gates power, clocks.
// RL3: Reset/off keeps block_ram only if keep set.
// RL4: Reset/off floats pins unless pin keep.
// RL5: Retention keeps config, gates power, clocks.
// RL6: Retention keeps block_ram only if enables zero.
// RL7: Retention pins keep driving last data.
// RL8: Both inputs high: configure, then fabric controls.
// RL9: Config memory loaded from store or serial.
// RL10: Pins 3 to 6 carry serial configuration.
// RL11: Flash mode drives serial clock out.
// RL12: Microcontroller supplies serial clock as input.
// RL13: Select pin input in flash, output otherwise.
// RL14: Data in on serial in, out serial out.
// RL15: Microcontroller mode flags config on serial out.
// RL16: Configuration pins released to user afterwards.
// RL17: User logic cannot reach loader.
// RL18: Power reset mid-load restarts loading from start.
//
// The address-and-strobe port and the register offsets were decided locally.
`include "cfg_load_map.vh"
`timescale 1ns/1ps
`default_nettype none

module config_load_power_state_ctrl #(
	parameter WORDS = 16,
	parameter AW = 4,
	parameter PINS = 19
) (
	input wire clk,
	input wire sys_rst,
	input wire powerOnReset,
	input wire arrayPowerReset_n,
	input wire retentionRequest_n,
	input wire [1:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdata,
	input wire [PINS-1:0] pinIn,
	output reg [PINS-1:0] pinOut,
	output reg [PINS-1:0] pinOe,
	input wire [PINS-1:0] userOut,
	input wire [PINS-1:0] userOe,
	output reg [AW-1:0] otpAddr,
	output wire otpEnable,
	input wire [7:0] otpData,
	output wire arrayPowerOn,
	output wire clockGenEnable,
	output wire oscEnable,
	output wire ramRetain,
	output wire configValid,
	output wire [8*WORDS-1:0] configImage
);

	localparam ST_OFF = 3'h0;
	localparam ST_RET = 3'h1;
	localparam ST_BOOT = 3'h2;
	localparam ST_OTP = 3'h3;
	localparam ST_FLASH = 3'h4;
	localparam ST_MCU = 3'h5;
	localparam ST_RUN = 3'h6;
	localparam integer HALF_I = `SCLK_HALF_CYC;
	localparam [7:0] HALF = HALF_I[7:0];

	// Three-stage synchronisers for every asynchronous input
	reg [2:0] porSync, arpSync, retSync, clkSync, selSync, sinSync;
	reg porLvl, arpLvl, retLvl, sclkLvl, selLvl, sinLvl;
	wire rst = sys_rst | porLvl;

	always @(posedge clk) begin
		porSync <= {porSync[1:0], powerOnReset};
		arpSync <= {arpSync[1:0], arrayPowerReset_n};
		retSync <= {retSync[1:0], retentionRequest_n};
		clkSync <= {clkSync[1:0], pinIn[`PIN_SCLK]};
		selSync <= {selSync[1:0], pinIn[`PIN_SEL]};
		sinSync <= {sinSync[1:0], pinIn[`PIN_SIN]};
	end

	reg sclkRise;
	always @(posedge clk) begin
		if (sys_rst) begin
			porLvl <= 1'b1;
		end else if (porSync[1] == porSync[2]) begin
			porLvl <= porSync[2];
		end
	end
	always @(posedge clk) begin
		if (rst) begin
			arpLvl <= 1'b0;
			retLvl <= 1'b0;
			sclkLvl <= 1'b0;
			selLvl <= 1'b1;
			sinLvl <= 1'b0;
			sclkRise <= 1'b0;
		end else begin
			if (arpSync[1] == arpSync[2])
				arpLvl <= arpSync[2];
			if (retSync[1] == retSync[2])
				retLvl <= retSync[2];
			if (selSync[1] == selSync[2])
				selLvl <= selSync[2];
			if (sinSync[1] == sinSync[2])
				sinLvl <= sinSync[2];
			sclkRise <= 1'b0;
			if (clkSync[1] == clkSync[2]) begin
				sclkRise <= clkSync[2] & ~sclkLvl;
				sclkLvl <= clkSync[2];
			end
		end
	end

	// Control register
	reg [7:0] ctrl;
	wire keepRam = ctrl[`CTRL_KEEP_RAM];
	wire pinKeep = ctrl[`CTRL_PIN_KEEP];
	wire ramEnAny = ctrl[`CTRL_RAM_EN_LO] | ctrl[`CTRL_RAM_EN_HI];
	wire [1:0] bootMode = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];

	reg [2:0] state;
	reg valid;
	reg overrun;
	reg [AW:0] wordCnt;
	reg [7:0] mem [0:WORDS-1];

	// Two-entry buffer between the store and serial sources and config memory
	reg [7:0] buf0, buf1;
	reg [1:0] bufCnt;
	reg pushValid;
	reg [7:0] pushData;
	wire bufReady = (bufCnt != 2'h2);
	wire bufValid = (bufCnt != 2'h0);
	wire loading = (state == ST_OTP) | (state == ST_FLASH) | (state == ST_MCU);
	wire drainReady = loading & (wordCnt < WORDS);
	wire push = pushValid & bufReady;
	wire pop = bufValid & drainReady;

	always @(posedge clk) begin
		if (rst | ~loading) begin
			bufCnt <= 2'h0;
		end else begin
			if (pop)
				buf0 <= buf1;
			if (push & (bufCnt == 2'h0 || (bufCnt == 2'h1 && pop)))
				buf0 <= pushData;
			if (push & (bufCnt == 2'h1) & ~pop)
				buf1 <= pushData;
			if (push & (bufCnt == 2'h2 - 2'h0) & pop)
				buf1 <= pushData;
			bufCnt <= bufCnt + {1'b0, push} - {1'b0, pop};
		end
	end

	// Config memory writes; cleared by reset/off
	genvar gi;
	generate
		for (gi = 0; gi < WORDS; gi = gi + 1) begin : g_img
			assign configImage[8*gi+7:8*gi] = mem[gi];
			always @(posedge clk) begin
				// RL2: config dropped
				if (rst | (state == ST_OFF))
					mem[gi] <= 8'h00;
				// RL9: load config memory
				else if (pop && wordCnt == gi)
					mem[gi] <= buf0;
			end
		end
	endgenerate

	// One-time store reader
	reg otpPend;
	wire otpIssue = (state == ST_OTP) & ~otpPend & (bufCnt == 2'h0)
		& ({1'b0, otpAddr} < WORDS) & ~valid;

	// Flash master and microcontroller slave shifters
	reg [7:0] divCnt;
	reg sclkOut;
	reg cmdPhase;
	reg [2:0] bitCnt;
	reg [7:0] txShift, rxShift;
	wire tick = (divCnt == HALF - 8'h01);

	reg [2:0] next_state;
	always @* begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (arpLvl)
					next_state = retLvl ? ST_BOOT : ST_RET;
			end
			ST_RET: begin
				if (retLvl)
					next_state = valid ? ST_RUN : ST_BOOT;
			end
			ST_BOOT: begin
				if (bootMode == `MODE_FLASH)
					next_state = ST_FLASH;
				else if (bootMode == `MODE_MCU)
					next_state = ST_MCU;
				else
					next_state = ST_OTP;
			end
			ST_OTP, ST_FLASH, ST_MCU: begin
				if (wordCnt == WORDS)
					next_state = ST_RUN;
				else if (~retLvl)
					next_state = ST_RET;
			end
			ST_RUN: begin
				if (~retLvl)
					next_state = ST_RET;
			end
			default: next_state = ST_OFF;
		endcase
		// RL18: restart on power reset
		if (~arpLvl)
			next_state = ST_OFF;
	end

	always @(posedge clk) begin
		if (rst) begin
			state <= ST_OFF;
			valid <= 1'b0;
			wordCnt <= {(AW+1){1'b0}};
			overrun <= 1'b0;
			otpAddr <= {AW{1'b0}};
			otpPend <= 1'b0;
			pushValid <= 1'b0;
			pushData <= 8'h00;
			divCnt <= 8'h00;
			sclkOut <= 1'b0;
			cmdPhase <= 1'b1;
			bitCnt <= 3'h0;
			txShift <= `FLASH_READ_CMD;
			rxShift <= 8'h00;
		end else begin
			state <= next_state;
			if (push)
				pushValid <= 1'b0;
			if (pop)
				wordCnt <= wordCnt + {{AW{1'b0}}, 1'b1};
			if (next_state == ST_RUN && wordCnt == WORDS)
				valid <= 1'b1;
			if (state == ST_OFF) begin
				valid <= 1'b0;
				wordCnt <= {(AW+1){1'b0}};
				otpAddr <= {AW{1'b0}};
				otpPend <= 1'b0;
				pushValid <= 1'b0;
				divCnt <= 8'h00;
				sclkOut <= 1'b0;
				cmdPhase <= 1'b1;
				bitCnt <= 3'h0;
				txShift <= `FLASH_READ_CMD;
			end
			// Store data arrives one cycle after the address
			otpPend <= otpIssue;
			if (otpIssue)
				otpAddr <= otpAddr + {{(AW-1){1'b0}}, 1'b1};
			if (otpPend) begin
				pushValid <= 1'b1;
				pushData <= otpData;
			end
			// RL11: master clock by divider
			if (state == ST_FLASH && ~selLvl) begin
				divCnt <= tick ? 8'h00 : divCnt + 8'h01;
				if (tick & ~sclkOut) begin
					// Stalls the clock low while the buffer is full
					if (cmdPhase | ~pushValid)
						sclkOut <= 1'b1;
				end else if (tick & sclkOut) begin
					// Sampled late in the high phase: the synchronised
					// data line lags the pin by several cycles
					sclkOut <= 1'b0;
					txShift <= {txShift[6:0], 1'b0};
					rxShift <= {rxShift[6:0], sinLvl};
					bitCnt <= bitCnt + 3'h1;
					if (bitCnt == 3'h7) begin
						if (cmdPhase)
							cmdPhase <= 1'b0;
						else begin
							pushValid <= 1'b1;
							pushData <= {rxShift[6:0], sinLvl};
						end
					end
				end
			end
			// RL12: sample external clock
			if (state == ST_MCU && sclkRise) begin
				rxShift <= {rxShift[6:0], sinLvl};
				bitCnt <= bitCnt + 3'h1;
				if (bitCnt == 3'h7) begin
					// Slave cannot stall the master; a full buffer drops the waiting byte, the new one replaces it
					if (pushValid)
						overrun <= 1'b1;
					pushValid <= 1'b1;
					pushData <= {rxShift[6:0], sinLvl};
				end
			end
			if (regWrite && regAddr == `REG_STATUS && regWdata[`STAT_OVERRUN])
				overrun <= 1'b0;
			if (state == ST_MCU && sclkRise && bitCnt == 3'h7 && pushValid)
				overrun <= 1'b1;
		end
	end

	// Register port: control writes, state reads one cycle later
	always @(posedge clk) begin
		if (rst) begin
			ctrl <= `CTRL_RESET;
			regRdata <= 8'h00;
		end else begin
			if (regWrite && regAddr == `REG_CTRL)
				ctrl <= regWdata;
			regRdata <= 8'h00;
			if (regRead) begin
				case (regAddr)
					`REG_CTRL: regRdata <= ctrl;
					`REG_STATUS: regRdata <= {3'h0, overrun, valid, state};
					`REG_COUNT: regRdata <= {{(7-AW){1'b0}}, wordCnt};
					default: regRdata <= 8'h00;
				endcase
			end
		end
	end

	// Power and clock enables
	// RL5: power gated in retention
	assign arrayPowerOn = (state != ST_OFF) & (state != ST_RET);
	// RL2: clocks and store off
	assign clockGenEnable = (state == ST_RUN);
	assign oscEnable = arrayPowerOn;
	assign otpEnable = (state == ST_OTP);
	// RL3: keep bit for reset
	// RL6: retention needs enables clear
	assign ramRetain = (state == ST_OFF) ? keepRam :
		(state == ST_RET) ? ~ramEnAny : 1'b1;
	assign configValid = valid;

	// Pin control, held copy kept for retention and pin keep
	reg [PINS-1:0] heldOut, heldOe;
	wire serialMode = (state == ST_FLASH) | (state == ST_MCU);
	always @(posedge clk) begin
		if (rst) begin
			heldOut <= {PINS{1'b0}};
			heldOe <= {PINS{1'b0}};
		end else if (state == ST_RUN) begin
			heldOut <= userOut;
			heldOe <= userOe;
		end else if (state == ST_OFF && ~pinKeep) begin
			heldOut <= {PINS{1'b0}};
			heldOe <= {PINS{1'b0}};
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			// RL1: pins float in reset
			pinOut <= {PINS{1'b0}};
			pinOe <= {PINS{1'b0}};
		end else begin
			pinOut <= {PINS{1'b0}};
			pinOe <= {PINS{1'b0}};
			case (state)
				// RL16: user owns pins
				// RL8: fabric controls pins
				ST_RUN: begin
					pinOut <= userOut;
					pinOe <= userOe;
				end
				// RL7: retention drives last data
				ST_RET: begin
					pinOut <= heldOut;
					pinOe <= heldOe;
				end
				// RL4: float unless kept
				ST_OFF: begin
					pinOut <= pinKeep ? heldOut : {PINS{1'b0}};
					pinOe <= pinKeep ? heldOe : {PINS{1'b0}};
				end
				default: begin
					// RL17: user drive masked
					// RL10: serial pins used
					if (state == ST_FLASH) begin
						// RL14: command out on serial out
						pinOut[`PIN_SCLK] <= sclkOut;
						pinOe[`PIN_SCLK] <= 1'b1;
						pinOut[`PIN_SOUT] <= txShift[7];
						pinOe[`PIN_SOUT] <= 1'b1;
					end else if (state == ST_MCU) begin
						// RL13: select is an output
						pinOut[`PIN_SEL] <= 1'b0;
						pinOe[`PIN_SEL] <= 1'b1;
						// RL15: config flag on serial out
						pinOut[`PIN_SOUT] <= (wordCnt == WORDS);
						pinOe[`PIN_SOUT] <= serialMode;
					end
				end
			endcase
		end
	end

endmodule

`default_nettype wire

//--- sim/config_load_power_state_ctrl_sva.sv
// Port-level checker for the power-state and configuration-load controller.
// Assumes clk domain only; bound to every instance of the controller.
`timescale 1ns/1ps
`default_nettype none
module config_load_power_state_ctrl_sva #(
	parameter PINS = 19
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic powerOnReset,
	input wire logic arrayPowerReset_n,
	input wire logic retentionRequest_n,
	input wire logic [PINS-1:0] pinOut,
	input wire logic [PINS-1:0] pinOe,
	input wire logic [PINS-1:0] userOe,
	input wire logic arrayPowerOn,
	input wire logic clockGenEnable,
	input wire logic oscEnable,
	input wire logic configValid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Load phase: powered, not yet valid, fabric clocks still off
	wire logic loading = arrayPowerOn & ~configValid & ~clockGenEnable;
	wire logic up = arrayPowerReset_n & retentionRequest_n & ~powerOnReset;
	por_float_a: assert property (powerOnReset [*6] |-> pinOe == '0)
		else $error("pins driven during power-on reset");
	off_gated_a: assert property (!arrayPowerReset_n [*8] |->
		!(arrayPowerOn | oscEnable | clockGenEnable | configValid)) else $error("reset state not gated");
	ret_gated_a: assert property ((arrayPowerReset_n && !retentionRequest_n) [*8] |->
		!(arrayPowerOn | oscEnable | clockGenEnable)) else $error("retention state not gated");
	ret_keep_a: assert property ((arrayPowerReset_n && !retentionRequest_n) [*8] |-> $stable(configValid))
		else $error("configuration lost in retention");
	run_clock_a: assert property ((up && configValid) [*8] |-> clockGenEnable && arrayPowerOn && oscEnable)
		else $error("run state clocks off");
	run_release_a: assert property ((up && configValid) [*8] |-> pinOe == $past(userOe))
		else $error("pins not released to user");
	sel_low_a: assert property (loading && pinOe[4] |-> !pinOut[4])
		else $error("select driven high during load");
	pins_iso_a: assert property (loading |-> pinOe[2:0] == 3'h0 && pinOe[PINS-1:7] == '0)
		else $error("non-serial pin driven during load");
	cover property ($rose(configValid));
	cover property (loading && pinOe[3]);
	cover property (arrayPowerReset_n && !retentionRequest_n && configValid);
endmodule
bind config_load_power_state_ctrl config_load_power_state_ctrl_sva #(.PINS(PINS)) i_config_load_power_state_ctrl_sva (
	.clk, .sys_rst, .powerOnReset, .arrayPowerReset_n, .retentionRequest_n, .pinOut, .pinOe, .userOe,
	.arrayPowerOn, .clockGenEnable, .oscEnable, .configValid);
`default_nettype wire

//--- sim/cfg_link_partner.sv
// Far side of the serial load link: a read-only flash or a loading microcontroller.
// Assumes devSclk/devSout are the controller's driven pin levels; run resets it.
`timescale 1ns/1ps
`default_nettype none
module cfg_link_partner #(
	parameter int WORDS = 16
) (
	input wire logic clk,
	input wire logic run,
	input wire logic mcu,
	input wire logic devSclk,
	input wire logic devSout,
	output logic sclk,
	output logic sel,
	output logic sin,
	output logic [7:0] cmd
);
	logic [10:0] n;
	logic [4:0] dly;
	logic [1:0] ph;
	logic seen, fsin, tog;
	function automatic logic bitOf(input logic [10:0] k);
		logic [7:0] b;
		b = {k[6:3], ~k[6:3]};
		return b[3'h7 - k[2:0]];
	endfunction
	assign sel = ~(run & ~mcu);
	// data MSB first; after the last bit the line toggles so nothing stale is seen
	assign sin = mcu ? (n < WORDS * 8 ? bitOf(n) : tog) : fsin;
	always @(posedge clk) begin
		tog <= ~tog;
		seen <= devSclk;
		if (!run) begin
			n <= '0;
			dly <= '0;
			ph <= '0;
			sclk <= 1'b0;
			fsin <= 1'b0;
			tog <= 1'b0;
		end else if (mcu) begin
			// processor supplies 80 ns clock, idle low after the frame
			if (dly != 5'h1F)
				dly <= dly + 5'h1;
			else if (n < WORDS * 8) begin
				ph <= ph + 2'h1;
				if (ph == 2'h3) begin
					sclk <= ~sclk;
					if (sclk)
						n <= n + 11'h1;
				end
			end
		end else if (devSclk && !seen) begin
			n <= n + 11'h1;
			if (n < 11'h8)
				cmd <= {cmd[6:0], devSout};
		end else if (!devSclk && seen)
			// flash answers at falling clock; command phase output is junk
			fsin <= n >= 11'h8 ? bitOf(n - 11'h8) : ~fsin;
	end
endmodule
`default_nettype wire

//--- sim/config_load_power_state_ctrl_tb.sv
// Self-checking bench: store, flash and microcontroller loads plus power states.
// Assumes the store model answers one cycle after the address, as the design expects.
`include "cfg_load_map.vh"
`timescale 1ns/1ps
`default_nettype none
module config_load_power_state_ctrl_tb;
	logic clk, sysRst, por, pwrN, retN, regWrite, regRead, mcu;
	logic [1:0] regAddr;
	logic [7:0] regWdata, otpData, d;
	logic [18:0] userOut, userOe;
	logic [127:0] img;
	wire logic [18:0] pinIn, pinOut, pinOe, ext;
	wire logic [7:0] regRdata, cmd;
	wire logic [3:0] otpAddr;
	wire logic otpEnable, arrayPowerOn, clockGenEnable, oscEnable, ramRetain, configValid, sclk, sel, sin;
	wire logic [127:0] configImage;
	int error_cnt, checked;
	assign ext = {13'h1A5A, sin, sel, sclk, 3'h5};
	assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
	config_load_power_state_ctrl i_config_load_power_state_ctrl (.clk(clk), .sys_rst(sysRst),
		.powerOnReset(por), .arrayPowerReset_n(pwrN), .retentionRequest_n(retN), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .userOut(userOut), .userOe(userOe), .otpAddr(otpAddr),
		.otpEnable(otpEnable), .otpData(otpData), .arrayPowerOn(arrayPowerOn), .clockGenEnable(clockGenEnable),
		.oscEnable(oscEnable), .ramRetain(ramRetain), .configValid(configValid), .configImage(configImage));
	cfg_link_partner i_cfg_link_partner (.clk(clk), .run(pwrN & retN), .mcu(mcu), .devSclk(pinOe[3] & pinOut[3]),
		.devSout(pinOe[6] & pinOut[6]), .sclk(sclk), .sel(sel), .sin(sin), .cmd(cmd));
	always @(posedge clk)
		otpData <= {otpAddr, ~otpAddr};
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [1:0] a);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task boot(input logic [1:0] m);
		wr(`REG_CTRL, {2'h0, m, 4'h0});
		mcu <= (m == `MODE_MCU);
		pwrN <= 1'b1;
		retN <= 1'b1;
		idle(300);
		if (m != `MODE_OTP)
			chk("serial clock drive", pinOe[`PIN_SCLK], m == `MODE_FLASH);
		repeat (3000) if (configValid !== 1'b1) @(posedge clk);
		idle(2);
		chk("image", configImage, img);
		chk("fabric clock", clockGenEnable, 1'b1);
		chk("released pins", pinOe, userOe);
		if (m == `MODE_FLASH)
			chk("flash command", cmd, `FLASH_READ_CMD);
	endtask
	task summarize;
		if (error_cnt == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#400000;
		error_cnt++;
		summarize();
	end
	initial begin
		{sysRst, por, pwrN, retN, regWrite, regRead, mcu} = 7'b1001000;
		regAddr = 2'h0;
		regWdata = 8'h00;
		userOut = 19'h2AAAA;
		userOe = 19'h7FF0F;
		for (int i = 0; i < 16; i++)
			img[8*i+:8] = {i[3:0], ~i[3:0]};
		repeat (16) @(posedge clk);
		sysRst <= 1'b0;
		idle(6);
		rd(`REG_CTRL);
		chk("ctrl reset", d, `CTRL_RESET);
		rd(2'h3);
		chk("unmapped read", d, 8'h00);
		chk("off pins", pinOe, 19'h0);
		chk("off ram", ramRetain, 1'b0);
		wr(`REG_CTRL, 8'h01);
		idle(2);
		chk("off ram kept", ramRetain, 1'b1);
		boot(`MODE_OTP);
		retN <= 1'b0;
		idle(10);
		chk("ret power", {arrayPowerOn, oscEnable, clockGenEnable}, 3'h0);
		chk("ret config", configValid, 1'b1);
		chk("ret pins", pinOe, userOe);
		chk("ret ram", ramRetain, 1'b1);
		wr(`REG_CTRL, 8'h04);
		idle(2);
		chk("ret ram lost", ramRetain, 1'b0);
		retN <= 1'b1;
		idle(10);
		chk("run again", clockGenEnable, 1'b1);
		pwrN <= 1'b0;
		idle(10);
		chk("off state", {arrayPowerOn, oscEnable, configValid, pinOe}, 22'h0);
		boot(`MODE_FLASH);
		pwrN <= 1'b0;
		idle(10);
		wr(`REG_CTRL, {2'h0, `MODE_MCU, 4'h0});
		mcu <= 1'b1;
		pwrN <= 1'b1;
		idle(400);
		chk("select out low", {pinOe[`PIN_SEL], pinOut[`PIN_SEL]}, 2'b10);
		pwrN <= 1'b0;
		idle(10);
		boot(`MODE_MCU);
		por <= 1'b1;
		idle(10);
		chk("por state", {configValid, pinOe}, 20'h0);
		por <= 1'b0;
		idle(4);
		summarize();
	end
endmodule
`default_nettype wire
